// [hdl/sps_consts.vh]
// Constants for the serial port setting select block
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// Register byte offsets
`define SPS_OFS_STATUS      4'h0
`define SPS_OFS_CTRL        4'h4
`define SPS_OFS_POSITION    4'h8
`define SPS_OFS_INPUTS      4'hC

// Status register fields
`define SPS_ST_IS485        0
`define SPS_ST_DONE         1
`define SPS_ST_ADDR_LSB     8
`define SPS_ST_RATE_LSB     16
`define SPS_ST_ADDR_NVM     18
`define SPS_ST_RATE_NVM     19
`define SPS_ST_RATE_SEL_LSB 20

// Control register fields and reset value
`define SPS_CT_MODE_LSB     0
`define SPS_CT_HALL_DIFF    4
`define SPS_CTRL_RST        2'h0

// Inputs register fields
`define SPS_IN_HALL_LSB     0
`define SPS_IN_FIVE         3
`define SPS_IN_SIX          4
`define SPS_IN_SW_LSB       8

// Switch field layout
`define SPS_SW_ADDR_LSB     0
`define SPS_SW_RATE_LSB     6

// Modes of the fifth and sixth inputs
`define SPS_MODE_GENERAL    2'h0
`define SPS_MODE_STEP_DIR   2'h1
`define SPS_MODE_AUX_QUAD   2'h2

// Bit-rate codes
`define SPS_RATE_FROM_NVM   2'h0
`define SPS_RATE_9K6        2'h1
`define SPS_RATE_38K4       2'h2
`define SPS_RATE_115K2      2'h3

// Reset values of captured settings and of the position count
`define SPS_ADDR_RST        6'h00
`define SPS_RATE_RST        2'h0
`define SPS_POS_RST         16'h0000

// Settle time before the switches are read
`define SPS_CLK_MHZ         25
`define SPS_SETTLE_NS       1000
`define SPS_SETTLE_CYC      ((`SPS_SETTLE_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_SETTLE_W        6

`endif

// [hdl/sps_quad_dec.v]
// Step/direction and quadrature counter for the fifth and sixth inputs
`timescale 1ns/1ps
`default_nettype none
`include "sps_consts.vh"

module sps_quad_dec (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Input pair and control
    input  wire        a_in,
    input  wire        b_in,
    input  wire [1:0]  mode,
    input  wire        clr,
    // Position
    output reg  [15:0] count_r
);

    reg         a_d_r;
    reg         b_d_r;
    reg  [15:0] count_nxt;
    wire        quad_en;
    wire        quad_up;
    wire        step_rise;

    // Exactly one edge of A or B moves the quadrature count
    assign quad_en   = a_in ^ a_d_r ^ b_in ^ b_d_r;
    assign quad_up   = a_in ^ b_d_r;
    assign step_rise = a_in & ~a_d_r;

    // Count update; clear wins since a stale position is worse than a lost step
    always @* begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = `SPS_POS_RST;
        end else if (mode == `SPS_MODE_STEP_DIR && step_rise) begin
            count_nxt = b_in ? count_r + 16'h0001 : count_r - 16'h0001;
        end else if (mode == `SPS_MODE_AUX_QUAD && quad_en) begin
            count_nxt = quad_up ? count_r + 16'h0001 : count_r - 16'h0001;
        end
    end

    // Previous input levels and the count
    always @(posedge clk) begin
        if (!rstn) begin
            a_d_r   <= 1'b0;
            b_d_r   <= 1'b0;
            count_r <= `SPS_POS_RST;
        end else begin
            a_d_r   <= a_in;
            b_d_r   <= b_in;
            count_r <= count_nxt;
        end
    end

endmodule // sps_quad_dec

`default_nettype wire

// [hdl/sps_top.v]
// Serial port setting select: switch decode, encoder buffers, input routing
//
// Function
// [R1] Select pin grounded means RS-485, else RS-232
// [R2] Switches one to six form node address
// [R3] Switches seven and eight form rate code
// [R4] RS-232 mode ignores address and rate switches
// [R5] Zero field falls back to stored value
// [R6] Rate codes 1,2,3 select 9.6/38.4/115.2 kbps
// [R7] Drive complementary buffered encoder A, B, index
// [R8] Inputs five, six: general, step/dir, auxiliary
// [R9] Hall complements used only when differential
// [R10] Sample settings once after reset, then hold
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sps_consts.vh"

module sps_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Configuration pins
    input  wire        port_sel_485_n,
    input  wire [7:0]  dip_sw,
    input  wire [5:0]  nvm_addr,
    input  wire [1:0]  nvm_rate,
    // Motor encoder
    input  wire        motor_quad_a_input,
    input  wire        motor_quad_b_input,
    input  wire        motor_index_input,
    // Commutation sensors
    input  wire [2:0]  hall_p,
    input  wire [2:0]  hall_n,
    // Multi-use inputs
    input  wire        multi_use_input_five,
    input  wire        multi_use_input_six,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Serial port settings
    output reg         serial_is_485,
    output reg         serial_enable,
    output reg  [5:0]  node_addr,
    output reg  [1:0]  rate_code,
    output reg  [2:0]  rate_sel,
    // Buffered encoder outputs
    output reg         buffered_quad_a_output,
    output reg         buffered_quad_a_output_n,
    output reg         buffered_quad_b_output,
    output reg         buffered_quad_b_output_n,
    output reg         buffered_index_output,
    output reg         buffered_index_output_n,
    // Decoded inputs
    output reg  [2:0]  hall_state,
    output reg         gp_in_five,
    output reg         gp_in_six
);

    // One-hot capture states
    localparam [3:0] ST_RESET   = 4'h1;
    localparam [3:0] ST_SETTLE  = 4'h2;
    localparam [3:0] ST_CAPTURE = 4'h4;
    localparam [3:0] ST_RUN     = 4'h8;

    reg  [3:0]               state_r;
    reg  [3:0]               state_nxt;
    reg  [`SPS_SETTLE_W-1:0] settle_r;
    reg  [`SPS_SETTLE_W-1:0] settle_nxt;
    reg                      addr_nvm_r;
    reg                      rate_nvm_r;
    reg  [7:0]               sw_cap_r;
    reg  [1:0]               mode_r;
    reg                      hall_diff_r;
    reg  [31:0]              rdata_nxt;
    wire [15:0]              position;
    wire                     pos_clr;
    wire [5:0]               sw_addr;
    wire [1:0]               sw_rate;
    wire                     use485;
    wire [5:0]               addr_eff;
    wire [1:0]               rate_eff;
    wire [2:0]               hall_nxt;

    // Switch fields
    assign sw_addr = dip_sw[`SPS_SW_ADDR_LSB +: 6];  // [R2]
    assign sw_rate = dip_sw[`SPS_SW_RATE_LSB +: 2];  // [R3]
    assign use485  = ~port_sel_485_n;                // [R1]

    // Stored value replaces a zero field or any field in RS-232 mode
    assign addr_eff = (!use485 || sw_addr == 6'h00) ? nvm_addr : sw_addr;  // [R4] [R5]
    assign rate_eff = (!use485 || sw_rate == `SPS_RATE_FROM_NVM) ? nvm_rate : sw_rate;  // [R4] [R5]

    // Capture sequencer: wait for pins to settle, then latch once
    always @* begin
        state_nxt  = state_r;
        settle_nxt = settle_r;
        case (state_r)
            ST_RESET: begin
                settle_nxt = {`SPS_SETTLE_W{1'b0}};
                state_nxt  = ST_SETTLE;
            end
            ST_SETTLE: begin
                settle_nxt = settle_r + 1'b1;
                if (settle_r == `SPS_SETTLE_CYC - 1) begin
                    state_nxt = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                state_nxt = ST_RUN;  // [R10]
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
    end

    // Held settings; only the capture state may load them
    always @(posedge clk) begin
        if (!rstn) begin
            state_r       <= ST_RESET;
            settle_r      <= {`SPS_SETTLE_W{1'b0}};
            serial_is_485 <= 1'b0;
            serial_enable <= 1'b0;
            node_addr     <= `SPS_ADDR_RST;
            rate_code     <= `SPS_RATE_RST;
            rate_sel      <= 3'h0;
            addr_nvm_r    <= 1'b0;
            rate_nvm_r    <= 1'b0;
            sw_cap_r      <= 8'h00;
        end else begin
            state_r  <= state_nxt;
            settle_r <= settle_nxt;
            if (state_r == ST_CAPTURE) begin
                serial_is_485 <= use485;                                    // [R1] [R10]
                node_addr     <= addr_eff;                                  // [R2] [R5]
                rate_code     <= rate_eff;                                  // [R3] [R5]
                addr_nvm_r    <= !use485 || sw_addr == 6'h00;
                rate_nvm_r    <= !use485 || sw_rate == `SPS_RATE_FROM_NVM;
                sw_cap_r      <= dip_sw;
                // Stored zero rate has no speed; leave every select low
                case (rate_eff)
                    `SPS_RATE_9K6:   rate_sel <= 3'h1;  // [R6]
                    `SPS_RATE_38K4:  rate_sel <= 3'h2;  // [R6]
                    `SPS_RATE_115K2: rate_sel <= 3'h4;  // [R6]
                    default:         rate_sel <= 3'h0;
                endcase
            end
            // Port comes up only once settings are stable
            serial_enable <= (state_r == ST_CAPTURE) || (state_r == ST_RUN);  // [R10]
        end
    end

    // Encoder buffers; one flop of delay, well inside the encoder rate
    always @(posedge clk) begin
        if (!rstn) begin
            buffered_quad_a_output   <= 1'b0;
            buffered_quad_a_output_n <= 1'b1;
            buffered_quad_b_output   <= 1'b0;
            buffered_quad_b_output_n <= 1'b1;
            buffered_index_output    <= 1'b0;
            buffered_index_output_n  <= 1'b1;
        end else begin
            buffered_quad_a_output   <= motor_quad_a_input;   // [R7]
            buffered_quad_a_output_n <= ~motor_quad_a_input;  // [R7]
            buffered_quad_b_output   <= motor_quad_b_input;   // [R7]
            buffered_quad_b_output_n <= ~motor_quad_b_input;  // [R7]
            buffered_index_output    <= motor_index_input;    // [R7]
            buffered_index_output_n  <= ~motor_index_input;   // [R7]
        end
    end

    // Hall receivers: differential pair holds its level while both legs agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_hall
            assign hall_nxt[gi] = !hall_diff_r ? hall_p[gi] :
                                  (hall_p[gi] != hall_n[gi]) ? hall_p[gi] :
                                  hall_state[gi];  // [R9]
        end
    endgenerate

    // Hall state and general-purpose copies of inputs five and six
    always @(posedge clk) begin
        if (!rstn) begin
            hall_state <= 3'h0;
            gp_in_five <= 1'b0;
            gp_in_six  <= 1'b0;
        end else begin
            hall_state <= hall_nxt;  // [R9]
            // General copies read low while the pair serves as a command
            gp_in_five <= (mode_r == `SPS_MODE_GENERAL) & multi_use_input_five;  // [R8]
            gp_in_six  <= (mode_r == `SPS_MODE_GENERAL) & multi_use_input_six;   // [R8]
        end
    end

    // Step/direction or auxiliary quadrature count
    assign pos_clr = reg_wr && reg_addr == `SPS_OFS_POSITION;

    sps_quad_dec u_quad (
        .clk     (clk),
        .rstn    (rstn),
        .a_in    (multi_use_input_five),
        .b_in    (multi_use_input_six),
        .mode    (mode_r),
        .clr     (pos_clr),
        .count_r (position)
    );

    // Control register writes
    always @(posedge clk) begin
        if (!rstn) begin
            mode_r      <= `SPS_CTRL_RST;
            hall_diff_r <= 1'b0;
        end else if (reg_wr && reg_addr == `SPS_OFS_CTRL) begin
            mode_r      <= reg_wdata[`SPS_CT_MODE_LSB +: 2];  // [R8]
            hall_diff_r <= reg_wdata[`SPS_CT_HALL_DIFF];     // [R9]
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (reg_addr)
            `SPS_OFS_STATUS: begin
                rdata_nxt[`SPS_ST_IS485]             = serial_is_485;
                rdata_nxt[`SPS_ST_DONE]              = serial_enable;
                rdata_nxt[`SPS_ST_ADDR_LSB +: 6]     = node_addr;
                rdata_nxt[`SPS_ST_RATE_LSB +: 2]     = rate_code;
                rdata_nxt[`SPS_ST_ADDR_NVM]          = addr_nvm_r;
                rdata_nxt[`SPS_ST_RATE_NVM]          = rate_nvm_r;
                rdata_nxt[`SPS_ST_RATE_SEL_LSB +: 3] = rate_sel;
            end
            `SPS_OFS_CTRL: begin
                rdata_nxt[`SPS_CT_MODE_LSB +: 2] = mode_r;
                rdata_nxt[`SPS_CT_HALL_DIFF]     = hall_diff_r;
            end
            `SPS_OFS_POSITION: begin
                rdata_nxt[15:0] = position;
            end
            `SPS_OFS_INPUTS: begin
                rdata_nxt[`SPS_IN_HALL_LSB +: 3] = hall_state;
                rdata_nxt[`SPS_IN_FIVE]          = multi_use_input_five;
                rdata_nxt[`SPS_IN_SIX]           = multi_use_input_six;
                rdata_nxt[`SPS_IN_SW_LSB +: 8]   = sw_cap_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
        end
    end

endmodule // sps_top

`default_nettype wire

// [tb/sps_cfg_host.sv]
// Model of the host side wiring of the select pin and switch bank
`timescale 1ns/1ps
`default_nettype none
module sps_cfg_host (
    // Wanted settings
    input  wire logic       want_485,
    input  wire logic [7:0] sw_set,
    // Pins into the drive
    output logic            port_sel_485_n,
    output logic [7:0]      dip_sw
);
    // Grounding the select pin asks for RS-485; left open it floats high
    assign port_sel_485_n = !want_485;
    // Switch on reads as one
    assign dip_sw = sw_set;
endmodule // sps_cfg_host
`default_nettype wire

// [tb/sps_top_monitor.sv]
// Assertion checker bound to the serial port setting select top
`timescale 1ns/1ps
`default_nettype none
module sps_top_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Configuration pins
    input wire logic       port_sel_485_n,
    input wire logic [7:0] dip_sw,
    input wire logic [5:0] nvm_addr,
    input wire logic [1:0] nvm_rate,
    // Motor encoder
    input wire logic       motor_quad_a_input,
    input wire logic       motor_quad_b_input,
    input wire logic       motor_index_input,
    // Settings
    input wire logic       serial_is_485,
    input wire logic       serial_enable,
    input wire logic [5:0] node_addr,
    input wire logic [1:0] rate_code,
    input wire logic [2:0] rate_sel,
    // Buffered encoder
    input wire logic       buffered_quad_a_output,
    input wire logic       buffered_quad_a_output_n,
    input wire logic       buffered_quad_b_output,
    input wire logic       buffered_quad_b_output_n,
    input wire logic       buffered_index_output,
    input wire logic       buffered_index_output_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Capture moment: the pins seen one edge earlier are the ones loaded
    sequence s_cap;
        $rose(serial_enable);
    endsequence
    sequence s_run;
        $past(rstn);
    endsequence
    a_sel_mode: assert property (s_cap |-> serial_is_485 == !$past(port_sel_485_n))
        else $error("serial mode differs from select pin");
    a_cap_addr: assert property (s_cap |-> node_addr == ((!$past(port_sel_485_n)
        && $past(dip_sw[5:0]) != 6'h00) ? $past(dip_sw[5:0]) : $past(nvm_addr)))
        else $error("captured node address wrong");
    a_cap_rate: assert property (s_cap |-> rate_code == ((!$past(port_sel_485_n)
        && $past(dip_sw[7:6]) != 2'h0) ? $past(dip_sw[7:6]) : $past(nvm_rate)))
        else $error("captured rate code wrong");
    a_rate_decode: assert property (serial_enable |-> rate_sel ==
        ((rate_code == 2'h0) ? 3'h0 : (3'h1 << (rate_code - 2'h1))))
        else $error("rate select not one-hot of code");
    a_settings_held: assert property (serial_enable |=> serial_enable
        && $stable(serial_is_485) && $stable(node_addr) && $stable(rate_code))
        else $error("settings moved after capture");
    a_enc_a_copy: assert property (s_run |-> buffered_quad_a_output == $past(motor_quad_a_input)
        && buffered_quad_a_output_n == !$past(motor_quad_a_input))
        else $error("buffered A pair wrong");
    a_enc_b_copy: assert property (s_run |-> buffered_quad_b_output == $past(motor_quad_b_input)
        && buffered_quad_b_output_n == !$past(motor_quad_b_input))
        else $error("buffered B pair wrong");
    a_enc_i_copy: assert property (s_run |-> buffered_index_output == $past(motor_index_input)
        && buffered_index_output_n == !$past(motor_index_input))
        else $error("buffered index pair wrong");
endmodule // sps_top_monitor
bind sps_top sps_top_monitor u_mon (.clk(clk), .rstn(rstn), .port_sel_485_n(port_sel_485_n),
    .dip_sw(dip_sw), .nvm_addr(nvm_addr), .nvm_rate(nvm_rate),
    .motor_quad_a_input(motor_quad_a_input), .motor_quad_b_input(motor_quad_b_input),
    .motor_index_input(motor_index_input), .serial_is_485(serial_is_485),
    .serial_enable(serial_enable), .node_addr(node_addr), .rate_code(rate_code),
    .rate_sel(rate_sel), .buffered_quad_a_output(buffered_quad_a_output),
    .buffered_quad_a_output_n(buffered_quad_a_output_n),
    .buffered_quad_b_output(buffered_quad_b_output),
    .buffered_quad_b_output_n(buffered_quad_b_output_n),
    .buffered_index_output(buffered_index_output),
    .buffered_index_output_n(buffered_index_output_n));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the serial port setting select block
`timescale 1ns/1ps
`default_nettype none
`include "sps_consts.vh"
module testbench;
    // Stimulus
    logic        clk, rstn, want_485, ma, mb, mi, in5, in6, reg_wr, reg_rd;
    logic [7:0]  sw_set;
    logic [5:0]  nvm_addr;
    logic [1:0]  nvm_rate;
    logic [2:0]  hall_p, hall_n;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    // Observed
    wire         sel_n, is485, en, qa, qan, qb, qbn, qi, qin, gp5, gp6;
    wire  [7:0]  dip_sw;
    wire  [5:0]  node_addr;
    wire  [1:0]  rate_code;
    wire  [2:0]  rate_sel, hall_state;
    wire  [31:0] reg_rdata;
    int          error_cnt = 0;
    int          samples_checked = 0;

    sps_cfg_host host (.want_485(want_485), .sw_set(sw_set), .port_sel_485_n(sel_n),
        .dip_sw(dip_sw));
    sps_top dut (.clk(clk), .rstn(rstn), .port_sel_485_n(sel_n), .dip_sw(dip_sw),
        .nvm_addr(nvm_addr), .nvm_rate(nvm_rate), .motor_quad_a_input(ma),
        .motor_quad_b_input(mb), .motor_index_input(mi), .hall_p(hall_p), .hall_n(hall_n),
        .multi_use_input_five(in5), .multi_use_input_six(in6), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_is_485(is485), .serial_enable(en), .node_addr(node_addr),
        .rate_code(rate_code), .rate_sel(rate_sel), .buffered_quad_a_output(qa),
        .buffered_quad_a_output_n(qan), .buffered_quad_b_output(qb),
        .buffered_quad_b_output_n(qbn), .buffered_index_output(qi),
        .buffered_index_output_n(qin), .hall_state(hall_state), .gp_in_five(gp5),
        .gp_in_six(gp6));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdx(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, e);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Reset with fixed pins, then wait a bounded time for capture
    task automatic boot(input logic s, input logic [7:0] sw, input logic [5:0] na,
                        input logic [1:0] nr);
        int n;
        @(posedge clk);
        rstn <= 1'b0; want_485 <= s; sw_set <= sw; nvm_addr <= na; nvm_rate <= nr;
        wait_cyc(15);
        check({en, qan, qbn, qin}, 4'h7);
        @(posedge clk);
        rstn <= 1'b1;
        n = 0;
        while (en !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        #1 check(en, 1'b1);
    endtask

    // Watchdog well past the expected few hundred cycles
    initial begin
        #(40 * 4000);
        error_cnt++;
        end_of_test();
    end

    // Main sequence
    initial begin
        logic        t_s [5]  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [7:0]  t_sw [5] = '{8'hC5, 8'h40, 8'hBF, 8'h00, 8'hFF};
        logic [5:0]  t_na [5] = '{6'h2A, 6'h2A, 6'h11, 6'h07, 6'h15};
        logic [1:0]  t_nr [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
        logic        ua, ur;
        logic [5:0]  ea;
        logic [1:0]  er;
        logic [2:0]  es;
        rstn = 1'b0; want_485 = 1'b0; sw_set = 8'h00; nvm_addr = 6'h00; nvm_rate = 2'h0;
        ma = 1'b0; mb = 1'b0; mi = 1'b0; in5 = 1'b0; in6 = 1'b0; hall_p = 3'h0;
        hall_n = 3'h0; reg_addr = 4'h0; reg_wdata = 32'h0000_0000; reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Each row: mode pin, switches, stored values
        for (int k = 0; k < 5; k++) begin
            boot(t_s[k], t_sw[k], t_na[k], t_nr[k]);
            ua = t_s[k] && t_sw[k][5:0] != 6'h00;
            ur = t_s[k] && t_sw[k][7:6] != 2'h0;
            ea = ua ? t_sw[k][5:0] : t_na[k];
            er = ur ? t_sw[k][7:6] : t_nr[k];
            es = (er == 2'h0) ? 3'h0 : (3'h1 << (er - 2'h1));
            check({is485, node_addr, rate_code, rate_sel}, {t_s[k], ea, er, es});
            rdx(`SPS_OFS_STATUS, 32'hFFFF_FFFF, {9'h0, es, !ur, !ua, er, 2'h0, ea, 7'h1, t_s[k]});
        end
        // Later pin changes and status writes are ignored
        want_485 <= 1'b1;
        sw_set <= 8'h3C;
        wr(`SPS_OFS_STATUS, 32'h0000_0000);
        wait_cyc(4);
        check({is485, node_addr, rate_code}, {1'b0, 6'h15, 2'h3});
        rdx(`SPS_OFS_INPUTS, 32'h0000_FF00, 32'h0000_FF00);
        rdx(4'h1, 32'hFFFF_FFFF, 32'h0000_0000);
        // Encoder buffers, all input patterns
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            {ma, mb, mi} <= k[2:0];
            wait_cyc(1);
            check({qa, qb, qi, qan, qbn, qin}, {k[2:0], ~k[2:0]});
        end
        // General mode passes the inputs through
        in5 <= 1'b1;
        wait_cyc(2);
        check({gp5, gp6}, 2'b10);
        // Step and heading: three forward steps, one back
        wr(`SPS_OFS_CTRL, {30'h0, `SPS_MODE_STEP_DIR});
        in5 <= 1'b0;
        in6 <= 1'b1;
        rdx(`SPS_OFS_CTRL, 32'h0000_0013, 32'h0000_0001);
        wr(`SPS_OFS_POSITION, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            in5 <= 1'b1;
            in6 <= (k < 3);
            @(posedge clk);
            in5 <= 1'b0;
        end
        wait_cyc(2);
        check({gp5, gp6}, 2'b00);
        rdx(`SPS_OFS_POSITION, 32'h0000_FFFF, 32'h0000_0002);
        // Auxiliary quadrature: one full forward cycle
        in6 <= 1'b0;
        wr(`SPS_OFS_CTRL, {30'h0, `SPS_MODE_AUX_QUAD});
        wr(`SPS_OFS_POSITION, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {in5, in6} <= (k == 0) ? 2'b10 : (k == 1) ? 2'b11 : (k == 2) ? 2'b01 : 2'b00;
            wait_cyc(2);
        end
        rdx(`SPS_OFS_POSITION, 32'h0000_FFFF, 32'h0000_0004);
        // Hall legs: single ended, then differential take and hold
        hall_p <= 3'h6;
        hall_n <= 3'h6;
        wr(`SPS_OFS_CTRL, 32'h0000_0000);
        wait_cyc(2);
        rdx(`SPS_OFS_INPUTS, 32'h0000_0007, 32'h0000_0006);
        wr(`SPS_OFS_CTRL, 32'h0000_0010);
        hall_p <= 3'h3;
        hall_n <= 3'h4;
        wait_cyc(2);
        check(hall_state, 3'h3);
        hall_p <= 3'h5;
        hall_n <= 3'h5;
        wait_cyc(3);
        check(hall_state, 3'h3);
        // Unused mode code: no count, general copies low, live bits still read
        wr(`SPS_OFS_CTRL, 32'h0000_0003);
        in5 <= 1'b1;
        wait_cyc(2);
        check({gp5, gp6}, 2'b00);
        rdx(`SPS_OFS_INPUTS, 32'h0000_0018, 32'h0000_0008);
        rdx(`SPS_OFS_POSITION, 32'h0000_FFFF, 32'h0000_0004);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
